// [verilog/csm_map.vh]
`ifndef CSM_MAP_VH
`define CSM_MAP_VH

// ****************************************************
// Register byte offsets
// ****************************************************
`define CSM_SENSE_CONTROL_REG 8'h00
`define CSM_FIRST_TIMER_OPTION_REG 8'h04
`define CSM_SECOND_TIMER_CONTROL_REG 8'h08
`define CSM_FIRST_TIMER_COUNT_REG 8'h0c
`define CSM_SECOND_TIMER_COUNT_REG 8'h10
`define CSM_STATUS_REG 8'h14

// ****************************************************
// Field positions
// ****************************************************
`define CSM_CTL_ENABLE 7
`define CSM_CTL_RANGE 6
`define CSM_CTL_POWER_HI 3
`define CSM_CTL_POWER_LO 2
`define CSM_CTL_OSC_OUT 1
`define CSM_CTL_FT_SENSE_SEL 0
`define CSM_OPT_FT_CLOCK_SOURCE 0
`define CSM_T2_SOURCE_HI 7
`define CSM_T2_SOURCE_LO 6
`define CSM_T2_GATE_ENABLE 1
`define CSM_T2_ON 0

// ****************************************************
// Encodings and reset values
// ****************************************************
`define CSM_T2_SOURCE_OSC 2'h3
`define CSM_T2_SOURCE_SYSCLK 2'h0
`define CSM_MODE_LOW_OFF 3'h0
`define CSM_MODE_NOISE 3'h4
`define CSM_RESP_OKAY 2'h0
`define CSM_RESP_DECERR 2'h3
`define CSM_RESET_BYTE 8'h00

`endif

// [verilog/csm_sense_ctrl.v]
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.vh"
// How it works
// - Range select clear picks the fixed internal thresholds, set picks the variable reference thresholds.
// - In the low range the power level gives off, low, medium or high current for 00, 01, 10, 11.
// - In the high range power level 00 is noise detection with pin current off, others are low, medium, high.
// - In noise detection the comparator keeps running so pin noise still produces count edges.
// - The oscillator output clocks the selected timer, so its count over the time base gives frequency.
// - First timer sense select set with its clock source bit clear makes the oscillator clock the first timer.
// - Second timer clock source 11 makes the oscillator clock the second timer.
// - Second timer is off when its on bit is 0, free runs with gate enable 0, and is gated with both set.
// - The oscillator keeps running during sleep while the module is enabled and not in off mode.
// - The first timer does not count during sleep.
module csm_sense_ctrl #(
  parameter FT_WIDTH = 8,
  parameter ST_WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire osc_comparator_in,
  input wire second_timer_gate_in,
  input wire sleep_active,
  output reg variable_ref_sel,
  output reg [1:0] current_level,
  output reg pin_current_enable,
  output reg osc_enable,
  output reg noise_detect_active
);

  // ****************************************************
  // Helpers
  // ****************************************************

  // Byte lane merge under a strobe
  function [7:0] csm_merge;
    input [7:0] old_byte;
    input [7:0] new_byte;
    input strobe;
    begin
      csm_merge = strobe ? new_byte : old_byte;
    end
  endfunction

  // Mode drives pin current unless off or noise detection
  function csm_drives_pin;
    input [2:0] mode;
    begin
      csm_drives_pin = (mode != `CSM_MODE_LOW_OFF) && (mode != `CSM_MODE_NOISE);
    end
  endfunction

  // ****************************************************
  // Control state
  // ****************************************************
  reg sense_module_enable;
  reg range_select;
  reg [1:0] power_level;
  reg first_timer_sense_clock_sel;
  reg first_timer_clock_source;
  reg [1:0] second_timer_clock_source;
  reg second_timer_gate_enable;
  reg second_timer_on;
  reg [FT_WIDTH-1:0] first_timer_count;
  reg [ST_WIDTH-1:0] second_timer_count;

  // Synchronisers for pin inputs
  reg osc_meta;
  reg osc_sync;
  reg osc_prev;
  reg gate_meta;
  reg gate_sync;

  // Mode code is range bit above power level
  wire [2:0] mode = {range_select, power_level};
  // Oscillator runs while enabled and not in off mode, sleep or not
  wire osc_live = sense_module_enable && (mode != `CSM_MODE_LOW_OFF);
  // Static output when off, one count edge per comparator rise otherwise
  wire osc_out = osc_live & osc_sync;
  wire osc_edge = osc_live & osc_sync & ~osc_prev;

  // ****************************************************
  // Analog control outputs
  // ****************************************************

  // Decode range and power into the analog controls
  always @(posedge aclk) begin
    if (!aresetn) begin
      variable_ref_sel <= 1'b0;
      current_level <= 2'h0;
      pin_current_enable <= 1'b0;
      osc_enable <= 1'b0;
      noise_detect_active <= 1'b0;
    end else begin
      variable_ref_sel <= range_select;
      current_level <= power_level;
      pin_current_enable <= sense_module_enable && csm_drives_pin(mode);
      osc_enable <= osc_live;
      noise_detect_active <= sense_module_enable && (mode == `CSM_MODE_NOISE);
    end
  end

  // Two flops on each pin, plus edge history
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      gate_meta <= 1'b0;
      gate_sync <= 1'b0;
    end else begin
      osc_meta <= osc_comparator_in;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      gate_meta <= second_timer_gate_in;
      gate_sync <= gate_meta;
    end
  end

  // ****************************************************
  // Timer count enables
  // ****************************************************
  wire ft_from_osc = first_timer_sense_clock_sel && !first_timer_clock_source;
  wire ft_from_sys = !first_timer_sense_clock_sel && !first_timer_clock_source;
  wire ft_tick = !sleep_active && (ft_from_osc ? osc_edge : ft_from_sys);
  wire st_run = second_timer_on && (!second_timer_gate_enable || gate_sync);
  wire st_from_osc = (second_timer_clock_source == `CSM_T2_SOURCE_OSC);
  wire st_from_sys = (second_timer_clock_source == `CSM_T2_SOURCE_SYSCLK);
  wire st_tick = st_run && (st_from_osc ? osc_edge : st_from_sys);

  // ****************************************************
  // AXI4-Lite write channel
  // ****************************************************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_hit = (aw_addr == `CSM_SENSE_CONTROL_REG) || (aw_addr == `CSM_FIRST_TIMER_OPTION_REG) ||
    (aw_addr == `CSM_SECOND_TIMER_CONTROL_REG) || (aw_addr == `CSM_FIRST_TIMER_COUNT_REG) ||
    (aw_addr == `CSM_SECOND_TIMER_COUNT_REG) || (aw_addr == `CSM_STATUS_REG);

  // Latch address and data in either order, answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CSM_RESP_OKAY : `CSM_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte images of the registers after a write
  wire [7:0] ctl_byte = csm_merge({sense_module_enable, range_select, 2'h0, power_level, 1'b0,
    first_timer_sense_clock_sel}, w_data[7:0], w_strb[0]);
  wire [7:0] opt_byte = csm_merge({7'h00, first_timer_clock_source}, w_data[7:0], w_strb[0]);
  wire [7:0] st_ctl_byte = csm_merge({second_timer_clock_source, 4'h0, second_timer_gate_enable,
    second_timer_on}, w_data[7:0], w_strb[0]);
  wire [31:0] ft_wide = {{(32-FT_WIDTH){1'b0}}, first_timer_count};
  wire [31:0] st_wide = {{(32-ST_WIDTH){1'b0}}, second_timer_count};
  wire [31:0] ft_new = {csm_merge(ft_wide[31:24], w_data[31:24], w_strb[3]),
    csm_merge(ft_wide[23:16], w_data[23:16], w_strb[2]),
    csm_merge(ft_wide[15:8], w_data[15:8], w_strb[1]),
    csm_merge(ft_wide[7:0], w_data[7:0], w_strb[0])};
  wire [31:0] st_new = {csm_merge(st_wide[31:24], w_data[31:24], w_strb[3]),
    csm_merge(st_wide[23:16], w_data[23:16], w_strb[2]),
    csm_merge(st_wide[15:8], w_data[15:8], w_strb[1]),
    csm_merge(st_wide[7:0], w_data[7:0], w_strb[0])};

  // Control registers and timers; a software write beats a count tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      sense_module_enable <= 1'b0;
      range_select <= 1'b0;
      power_level <= 2'h0;
      first_timer_sense_clock_sel <= 1'b0;
      first_timer_clock_source <= 1'b0;
      second_timer_clock_source <= 2'h0;
      second_timer_gate_enable <= 1'b0;
      second_timer_on <= 1'b0;
      first_timer_count <= {FT_WIDTH{1'b0}};
      second_timer_count <= {ST_WIDTH{1'b0}};
    end else begin
      if (ft_tick) begin
        first_timer_count <= first_timer_count + {{(FT_WIDTH-1){1'b0}}, 1'b1};
      end
      if (st_tick) begin
        second_timer_count <= second_timer_count + {{(ST_WIDTH-1){1'b0}}, 1'b1};
      end
      if (do_write) begin
        case (aw_addr)
          `CSM_SENSE_CONTROL_REG: begin
            sense_module_enable <= ctl_byte[`CSM_CTL_ENABLE];
            range_select <= ctl_byte[`CSM_CTL_RANGE];
            power_level <= ctl_byte[`CSM_CTL_POWER_HI:`CSM_CTL_POWER_LO];
            first_timer_sense_clock_sel <= ctl_byte[`CSM_CTL_FT_SENSE_SEL];
          end
          `CSM_FIRST_TIMER_OPTION_REG: begin
            first_timer_clock_source <= opt_byte[`CSM_OPT_FT_CLOCK_SOURCE];
          end
          `CSM_SECOND_TIMER_CONTROL_REG: begin
            second_timer_clock_source <= st_ctl_byte[`CSM_T2_SOURCE_HI:`CSM_T2_SOURCE_LO];
            second_timer_gate_enable <= st_ctl_byte[`CSM_T2_GATE_ENABLE];
            second_timer_on <= st_ctl_byte[`CSM_T2_ON];
          end
          `CSM_FIRST_TIMER_COUNT_REG: begin
            first_timer_count <= ft_new[FT_WIDTH-1:0];
          end
          `CSM_SECOND_TIMER_COUNT_REG: begin
            second_timer_count <= st_new[ST_WIDTH-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************
  // AXI4-Lite read channel
  // ****************************************************
  assign s_axi_arready = !s_axi_rvalid;

  // Read data mux with decode error for holes
  reg [31:0] rd_word;
  reg rd_hit;
  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      `CSM_SENSE_CONTROL_REG: rd_word = {24'h000000, sense_module_enable, range_select, 2'h0,
        power_level, osc_out, first_timer_sense_clock_sel};
      `CSM_FIRST_TIMER_OPTION_REG: rd_word = {31'h00000000, first_timer_clock_source};
      `CSM_SECOND_TIMER_CONTROL_REG: rd_word = {24'h000000, second_timer_clock_source, 4'h0,
        second_timer_gate_enable, second_timer_on};
      `CSM_FIRST_TIMER_COUNT_REG: rd_word = ft_wide;
      `CSM_SECOND_TIMER_COUNT_REG: rd_word = st_wide;
      `CSM_STATUS_REG: rd_word = {24'h000000, 1'b0, gate_sync, osc_live, osc_out, 1'b0, mode};
      default: rd_hit = 1'b0;
    endcase
  end

  // Registered read answer, one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CSM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `CSM_RESP_OKAY : `CSM_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [sim/csm_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module csm_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic variable_ref_sel,
  input wire logic [1:0] current_level,
  input wire logic pin_current_enable,
  input wire logic osc_enable,
  input wire logic noise_detect_active
);
  // ****************************
  // Write decode
  // ****************************
  wire both_in = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ctl_in = both_in && s_axi_awaddr == 8'h00 && s_axi_wstrb[0];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Mode outputs against control writes and against each other
  property p_range; ctl_in |-> ##3 variable_ref_sel == $past(s_axi_wdata[6], 3); endproperty
  a_range: assert property (p_range) else $error("range output lags write");
  property p_level; ctl_in |-> ##3 current_level == $past(s_axi_wdata[3:2], 3); endproperty
  a_level: assert property (p_level) else $error("level output lags write");
  property p_noise; noise_detect_active == (osc_enable && variable_ref_sel && current_level == 2'h0); endproperty
  a_noise: assert property (p_noise) else $error("noise mode decode wrong");
  property p_pin; pin_current_enable == (osc_enable && !noise_detect_active); endproperty
  a_pin: assert property (p_pin) else $error("pin current decode wrong");
  property p_off; !variable_ref_sel && current_level == 2'h0 |-> !osc_enable; endproperty
  a_off: assert property (p_off) else $error("oscillator live in off mode");
  // Bus handshakes, then cover points
  property p_resp; both_in |-> ##2 s_axi_bvalid; endproperty
  a_resp: assert property (p_resp) else $error("write response late");
  property p_rdat; s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid; endproperty
  a_rdat: assert property (p_rdat) else $error("read data late");
  property p_bblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bblock: assert property (p_bblock) else $error("write taken during response");
  property p_arblock; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblock: assert property (p_arblock) else $error("read taken during data");
  c_noise: cover property (noise_detect_active);
  c_ctl: cover property (ctl_in);
  c_pin: cover property (pin_current_enable);
endmodule
bind csm_sense_ctrl csm_checker chk_u (.*);
`default_nettype wire

// [sim/csm_osc_model.sv]
`timescale 1ns/100ps
`default_nettype none
module csm_osc_model (
  input wire logic run,
  input wire logic slow,
  output logic comp
);
  // Comparator swings while pin activity is present, idle low otherwise
  initial begin
    comp = 1'h0;
    forever begin
      #(slow ? 370 : 130);
      comp = run ? !comp : 1'h0;
    end
  end
endmodule
`default_nettype wire

// [sim/csm_sense_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module cap_sense_mode_and_timer_clocking_tb;
  // ****************************
  // Stimulus and observed signals
  // ****************************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic second_timer_gate_in = 1'h0, sleep_active = 1'h0, run = 1'h0, slow = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_comparator_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, current_level;
  logic variable_ref_sel, pin_current_enable, osc_enable, noise_detect_active;
  int failures = 0, checks = 0, edges = 0;
  int hi, lo, thr;
  logic [15:0] lf = 16'h05a8;
  logic [31:0] tbl [8] = '{32'h8c01c100, 32'h8c01c300, 32'h8c01c302, 32'h8c01c202,
                           32'hc001c100, 32'h8001c100, 32'h8d004100, 32'h8d00c101};
  csm_sense_ctrl dut_u (.*);
  csm_osc_model osc_u (.run(run), .slow(slow), .comp(osc_comparator_in));
  always #20 aclk = ~aclk;
  // Count every rise the oscillator delivers
  always @(posedge osc_comparator_in) edges++;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    chk(nm, s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
  endtask
  // One timed measurement, expectation from the mode and timer settings
  task automatic meas(input logic [31:0] w);
    int n;
    logic live, e1, e2;
    second_timer_gate_in <= w[1];
    sleep_active <= w[0];
    wr(8'h00, {24'h0, w[31:24]}, 2'h0);
    wr(8'h04, {24'h0, w[23:16]}, 2'h0);
    wr(8'h08, {24'h0, w[15:8]}, 2'h0);
    wr(8'h0c, 32'h0, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    lf = nxt(lf);
    n = edges;
    run <= 1'h1;
    slow <= lf[0];
    repeat (24 + lf[6:1]) @(posedge aclk);
    run <= 1'h0;
    repeat (16) @(posedge aclk);
    n = edges - n;
    live = w[31] && {w[30], w[27:26]} != 3'h0;
    e1 = live && w[24] && !w[16] && !w[0];
    e2 = live && w[15:14] == 2'h3 && w[8] && (!w[9] || w[1]);
    rd(8'h0c, e1 ? n % 256 : 0, 2'h0, "first_count");
    rd(8'h10, e2 ? n : 0, 2'h0, "second_count");
  endtask
  // Gate held open for one first timer overflow period, single pulse style
  task automatic pad(input logic ld, output int got);
    int n;
    wr(8'h10, 32'h0, 2'h0);
    wr(8'h0c, 32'h0, 2'h0);
    n = edges;
    second_timer_gate_in <= 1'h1;
    slow <= ld;
    repeat (4) @(posedge aclk);
    run <= 1'h1;
    repeat (200) @(posedge aclk);
    run <= 1'h0;
    repeat (52) @(posedge aclk);
    second_timer_gate_in <= 1'h0;
    rd(8'h10, edges - n, 2'h0, "pad_count");
    got = s_axi_rdata;
  endtask
  task results;
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    results();
  end
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a < 12; a += 4) begin
      rd(a[7:0], 32'h0, 2'h0, "reset_value");
    end
    for (int m = 0; m < 8; m++) begin
      wr(8'h00, {24'h0, 1'h1, m[2], 2'h0, m[1:0], 2'h0}, 2'h0);
      rd(8'h14, {26'h0, m != 0, 1'h0, 1'h0, m[2:0]}, 2'h0, "status");
      chk("range_out", variable_ref_sel, m[2]);
      chk("level_out", current_level, m[1:0]);
      chk("pin_current", pin_current_enable, m != 0 && m != 4);
      chk("noise_mode", noise_detect_active, m == 4);
      chk("osc_on", osc_enable, m != 0);
    end
    wr(8'h20, 32'h0000005a, 2'h3);
    rd(8'h20, 32'h0, 2'h3, "unmapped");
    lf = nxt(lf);
    wr(8'h10, {16'h0, lf}, 2'h0);
    rd(8'h10, {16'h0, lf}, 2'h0, "second_count_rw");
    // Byte strobes on a counter write
    s_axi_wstrb <= 4'h2;
    wr(8'h10, 32'hffffffff, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h10, {16'h0, 8'hff, lf[7:0]}, 2'h0, "second_count_bytes");
    foreach (tbl[i]) begin
      meas(tbl[i]);
    end
    // Bare and loaded pad over one time base, threshold midway
    wr(8'h00, 32'h0000008c, 2'h0);
    wr(8'h04, 32'h00000000, 2'h0);
    wr(8'h08, 32'h000000c3, 2'h0);
    pad(1'h0, hi);
    pad(1'h1, lo);
    thr = (hi + lo) / 2;
    chk("loaded_below", lo < thr, 1'h1);
    chk("bare_above", hi > thr, 1'h1);
    results();
  end
endmodule
`default_nettype wire
